// >>> design/vdr_pkg.sv
// Shared constants for the sliced-data and letterbox readback bank
package vdr_pkg;

  // Register subaddresses
  localparam logic [7:0] VDR_ADDR_FOUND       = 8'h90;
  localparam logic [7:0] VDR_ADDR_WIDE1       = 8'h91;
  localparam logic [7:0] VDR_ADDR_WIDE2       = 8'h92;
  localparam logic [7:0] VDR_ADDR_ENH1        = 8'h93;
  localparam logic [7:0] VDR_ADDR_ENH2        = 8'h94;
  localparam logic [7:0] VDR_ADDR_ENH3        = 8'h95;
  localparam logic [7:0] VDR_ADDR_COPY1       = 8'h96;
  localparam logic [7:0] VDR_ADDR_COPY2       = 8'h97;
  localparam logic [7:0] VDR_ADDR_COPY3       = 8'h98;
  localparam logic [7:0] VDR_ADDR_CAP1        = 8'h99;
  localparam logic [7:0] VDR_ADDR_CAP2        = 8'h9A;
  localparam logic [7:0] VDR_ADDR_LB_TOP      = 8'h9B;
  localparam logic [7:0] VDR_ADDR_LB_MID      = 8'h9C;
  localparam logic [7:0] VDR_ADDR_LB_BOT      = 8'h9D;

  // Status bit positions in the found register
  localparam int VDR_FOUND_WIDE_BIT = 0;
  localparam int VDR_FOUND_CAP_BIT  = 1;
  localparam int VDR_FOUND_ENH_BIT  = 2;
  localparam int VDR_FOUND_COPY_BIT = 3;

  // Payload widths of the sliced services
  localparam int VDR_WIDE_W = 14;
  localparam int VDR_ENH_W  = 20;
  localparam int VDR_COPY_W = 20;
  localparam int VDR_CAP_W  = 16;

  // Parity position inside a caption byte
  localparam int VDR_PARITY_BIT = 7;

  // Reserved bit of the third enhanced-definition byte
  localparam int VDR_ENH3_RSVD_BIT = 5;

  // Letterbox measurement
  localparam int         VDR_LINE_W     = 10;
  localparam logic [7:0] VDR_BLACK_LUMA = 8'h20;
  localparam logic [7:0] VDR_CNT_MAX    = 8'hFF;

  // Reset values
  localparam logic [7:0] VDR_BYTE_RST = 8'h00;

endpackage

// >>> design/vdr_line_if.sv
// Carrier from the line judge to the letterbox field logic
`timescale 1ns/1ps
`default_nettype none
interface vdr_line_if;
  logic line_done;   // One-cycle pulse, a line of active video has ended
  logic line_black;  // Valid with line_done, every pixel was at or below black
  logic field_done;  // One-cycle pulse, field ended, in the same cycle as its last line_done
  modport judge (output line_done, output line_black, output field_done);
  modport field (input line_done, input line_black, input field_done);
endinterface
`default_nettype wire

// >>> design/vdr_svc_capture.sv
// Capture of one sliced service payload and its detection flag
`timescale 1ns/1ps
`default_nettype none
module vdr_svc_capture
  import vdr_pkg::*;
#(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk_sys_in,
  input  wire logic         rstn_in,
  // Slicer side
  input  wire logic         valid_in,
  input  wire logic [W-1:0] data_in,
  input  wire logic         field_start_in,
  // Bank side
  output logic      [W-1:0] data_out,
  output logic              found_out
);

  typedef struct packed {
    logic [W-1:0] data;
    logic         got;
    logic         found;
  } vdr_svc_state_t;

  vdr_svc_state_t state_reg;
  vdr_svc_state_t state_next;

  // Payload holds until the next decode; flag follows the last field
  always_comb begin
    state_next = state_reg;
    if (field_start_in) begin
      state_next.found = state_reg.got;
      state_next.got   = 1'b0;
    end
    // A decode in the boundary cycle wins over the field clear
    if (valid_in) begin
      state_next.data  = data_in;
      state_next.got   = 1'b1;
      state_next.found = 1'b1;
    end
  end

  // State register, cleared by reset
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign data_out  = state_reg.data;
  assign found_out = state_reg.found;

endmodule // vdr_svc_capture
`default_nettype wire

// >>> design/vdr_line_judge.sv
// Per-line black detector working on the luma stream alone
`timescale 1ns/1ps
`default_nettype none
module vdr_line_judge
  import vdr_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rstn_in,
  // Video timing and pixels
  input  wire logic       pix_valid_in,
  input  wire logic [7:0] luma_in,
  input  wire logic       line_start_in,
  input  wire logic       field_start_in,
  input  wire logic       field_end_in,
  // Line verdicts
  vdr_line_if.judge       line_if
);

  typedef struct packed {
    logic in_field;
    logic seen;
    logic black;
    logic done;
    logic verdict;
    logic fdone;
  } vdr_judge_state_t;

  vdr_judge_state_t state_reg;
  vdr_judge_state_t state_next;

  // Close a line at the next line start or at field end
  always_comb begin
    state_next       = state_reg;
    state_next.done  = 1'b0;
    state_next.fdone = 1'b0;
    if (state_reg.in_field && state_reg.seen && (line_start_in || field_end_in)) begin
      state_next.done    = 1'b1;
      state_next.verdict = state_reg.black;
    end
    if (field_end_in && state_reg.in_field) begin
      state_next.fdone    = 1'b1;
      state_next.in_field = 1'b0;
    end
    if (field_start_in) begin
      state_next.in_field = 1'b1;
    end
    if (line_start_in || field_start_in) begin
      state_next.seen  = 1'b0;
      state_next.black = 1'b1;
    end
    if (pix_valid_in && state_next.in_field) begin
      state_next.seen = 1'b1;
      if (luma_in > VDR_BLACK_LUMA) begin
        state_next.black = 1'b0;
      end
    end
  end

  // State register, cleared by reset
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign line_if.line_done  = state_reg.done;
  assign line_if.line_black = state_reg.verdict;
  assign line_if.field_done = state_reg.fdone;

endmodule // vdr_line_judge
`default_nettype wire

// >>> design/vdr_readback.sv
// Read-only bank of sliced VBI data and letterbox line counts
//
// What this block does
// - Wide-screen payload reads back in two byte registers, top two bits of the second read 0.
// - Enhanced-definition payload reads back in three bytes, bits 7 and 6 of the third read 0.
// - Bit 5 of the third enhanced-definition byte is reserved and carries no meaning.
// - The first caption byte register holds the caption parity bit in bit 7 above seven data bits.
// - The second caption byte register also holds its parity bit in bit 7.
// - The run of black lines at the top of active video is counted and read as 8 bits.
// - With subtitles present, black lines in the lower half of active video are counted and read.
// - The run of black lines at the bottom of active video is counted and read as 8 bits.
// - Each field is inspected at its start and its end and the counts are refreshed once per field.
// - Line counting uses picture content only, independent of any sliced signalling.
// - A status register shows wide-screen, caption, enhanced and copy detection in bits 0 to 3.
//
// Register map, all read-only; other subaddresses read 8'h00
// 8'h90  found flags: bit 0 wide, 1 caption, 2 enhanced, 3 copy
// 8'h91  wide-screen payload bits 7..0
// 8'h92  wide-screen payload bits 13..8, bits 7..6 read 0
// 8'h93  enhanced payload bits 7..0
// 8'h94  enhanced payload bits 15..8
// 8'h95  enhanced payload bits 19..16, bits 7..4 read 0
// 8'h96  copy payload bits 7..0
// 8'h97  copy payload bits 15..8
// 8'h98  copy payload bits 19..16, bits 7..4 read 0
// 8'h99  first caption byte as received, parity in bit 7
// 8'h9a  second caption byte as received, parity in bit 7
// 8'h9b  black lines above the picture
// 8'h9c  black lines in the lower half, 0 without subtitles
// 8'h9d  black lines below the picture
//
// Timing
// A read taken on one edge answers on the next: valid for one cycle,
// the byte standing until the next read; reads may run back to back.
// Counts of a field are published one cycle after its end strobe.
// Keep two cycles between a field end and the next field start: a
// start in the publish cycle drops the counts of the field just ended.
// Every input is taken as synchronous to the one core clock.
//
// Limitations
// Caption parity is passed through, never checked.
// Reserved and undefined bits read 0; counts stop at 255.
// Bytes of one payload are not frozen together, see the read mux.
// A field in which no line closed publishes zero counts.
// Found flags follow whole fields, see the capture module.
`timescale 1ns/1ps
`default_nettype none
module vdr_readback
  import vdr_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_sys_in,
  input  wire logic                  rstn_in,
  // Wide-screen slicer
  input  wire logic                  wide_valid_in,
  input  wire logic [VDR_WIDE_W-1:0] wide_data_in,
  // Enhanced-definition slicer
  input  wire logic                  enh_valid_in,
  input  wire logic [VDR_ENH_W-1:0]  enh_data_in,
  // Copy-management slicer
  input  wire logic                  copy_valid_in,
  input  wire logic [VDR_COPY_W-1:0] copy_data_in,
  // Caption slicer, two bytes as received, parity in bit 7 of each
  input  wire logic                  cap_valid_in,
  input  wire logic [VDR_CAP_W-1:0]  cap_data_in,
  // Active video
  input  wire logic                  pix_valid_in,
  input  wire logic [7:0]            luma_in,
  input  wire logic                  line_start_in,
  input  wire logic                  field_start_in,
  input  wire logic                  field_end_in,
  // Register read port, subaddressed
  input  wire logic                  reg_rd_in,
  input  wire logic [7:0]            reg_addr_in,
  output logic      [7:0]            reg_rdata_out,
  output logic                       reg_rvalid_out
);

  // Bank state. The open field's counters are never read by the host;
  // only the *_out copies are, so a read in mid-field sees the result
  // of the whole previous field and never a count still growing.
  typedef struct packed {
    logic [7:0]            rdata;
    logic                  rvalid;
    logic [VDR_LINE_W-1:0] line_cnt;
    logic [VDR_LINE_W-1:0] prev_total;
    logic [7:0]            top_cnt;
    logic                  top_done;
    logic [7:0]            bot_run;
    logic [7:0]            mid_cnt;
    logic                  low_black;
    logic                  subtitle;
    logic [7:0]            top_out;
    logic [7:0]            mid_out;
    logic [7:0]            bot_out;
  } vdr_bank_state_t;

  vdr_bank_state_t state_reg;
  vdr_bank_state_t state_next;

  vdr_line_if line_if ();

  logic [VDR_WIDE_W-1:0] wide_data;
  logic [VDR_ENH_W-1:0]  enh_data;
  logic [VDR_COPY_W-1:0] copy_data;
  logic [VDR_CAP_W-1:0]  cap_data;
  logic                  wide_found;
  logic                  enh_found;
  logic                  copy_found;
  logic                  cap_found;
  logic                  lower_half;

  // Saturating 8-bit line count, a tall black border must not wrap
  // to a small value and pass for a thin one
  function automatic logic [7:0] vdr_sat_inc(input logic [7:0] v);
    vdr_sat_inc = (v == VDR_CNT_MAX) ? v : v + 8'h01;
  endfunction

  // Each capture keeps the last payload of its service until a newer
  // one arrives, so a service that drops out still reads its old bytes;
  // the found flag tells the host whether the bytes are current.
  // One capture per sliced service
  vdr_svc_capture #(.W(VDR_WIDE_W)) u_wide (
    .clk_sys_in     (clk_sys_in),
    .rstn_in        (rstn_in),
    .valid_in       (wide_valid_in),
    .data_in        (wide_data_in),
    .field_start_in (field_start_in),
    .data_out       (wide_data),
    .found_out      (wide_found)
  );

  vdr_svc_capture #(.W(VDR_ENH_W)) u_enh (
    .clk_sys_in     (clk_sys_in),
    .rstn_in        (rstn_in),
    .valid_in       (enh_valid_in),
    .data_in        (enh_data_in),
    .field_start_in (field_start_in),
    .data_out       (enh_data),
    .found_out      (enh_found)
  );

  vdr_svc_capture #(.W(VDR_COPY_W)) u_copy (
    .clk_sys_in     (clk_sys_in),
    .rstn_in        (rstn_in),
    .valid_in       (copy_valid_in),
    .data_in        (copy_data_in),
    .field_start_in (field_start_in),
    .data_out       (copy_data),
    .found_out      (copy_found)
  );

  vdr_svc_capture #(.W(VDR_CAP_W)) u_cap (
    .clk_sys_in     (clk_sys_in),
    .rstn_in        (rstn_in),
    .valid_in       (cap_valid_in),
    .data_in        (cap_data_in),
    .field_start_in (field_start_in),
    .data_out       (cap_data),
    .found_out      (cap_found)
  );

  // The judge sees only pixels and timing, never the sliced payloads,
  // so the format can be inferred from the picture with no signalling
  // present at all.
  // Black-line verdict per line of active video
  vdr_line_judge u_judge (
    .clk_sys_in     (clk_sys_in),
    .rstn_in        (rstn_in),
    .pix_valid_in   (pix_valid_in),
    .luma_in        (luma_in),
    .line_start_in  (line_start_in),
    .field_start_in (field_start_in),
    .field_end_in   (field_end_in),
    .line_if        (line_if.judge)
  );

  // Lower half judged against the previous field's height, since the
  // present height is unknown until the field ends; the first field
  // after reset therefore has no lower half
  assign lower_half = (state_reg.prev_total != '0) &&
                      (state_reg.line_cnt >= (state_reg.prev_total >> 1));

  // Letterbox pass, once per field:
  // line_cnt numbers the closed lines of the field from zero;
  // top_cnt grows while every line so far was black, then freezes;
  // bot_run grows on black lines and restarts on a picture line, so
  // at field end it holds the trailing black run;
  // mid_cnt counts black lower-half lines and is published only when
  // a picture line followed one of them, taken to be a subtitle row.
  // A subtitle row that is itself dark enough to pass for black is
  // not told apart from the border; the threshold is a trade between
  // dim pictures read as black and grey borders read as picture.
  // Letterbox field logic
  always_comb begin
    state_next        = state_reg;
    // Valid pulses one cycle per taken read
    state_next.rvalid = 1'b0;
    if (field_start_in) begin
      state_next.line_cnt  = '0;
      state_next.top_cnt   = VDR_BYTE_RST;
      state_next.top_done  = 1'b0;
      state_next.bot_run   = VDR_BYTE_RST;
      state_next.mid_cnt   = VDR_BYTE_RST;
      state_next.low_black = 1'b0;
      state_next.subtitle  = 1'b0;
    end else if (line_if.line_done) begin
      // Line index stops at the top of its range
      if (state_reg.line_cnt != '1) begin
        state_next.line_cnt = state_reg.line_cnt + VDR_LINE_W'(1);
      end
      if (line_if.line_black) begin
        if (!state_reg.top_done) begin
          state_next.top_cnt = vdr_sat_inc(state_reg.top_cnt);
        end
        state_next.bot_run = vdr_sat_inc(state_reg.bot_run);
        if (lower_half) begin
          state_next.mid_cnt   = vdr_sat_inc(state_reg.mid_cnt);
          state_next.low_black = 1'b1;
        end
      end else begin
        // A picture line ends the top run and restarts the bottom run
        state_next.top_done = 1'b1;
        state_next.bot_run  = VDR_BYTE_RST;
        // picture below black band means subtitles
        if (lower_half && state_reg.low_black) begin
          state_next.subtitle = 1'b1;
        end
      end
    end
    if (line_if.field_done && !field_start_in) begin
      state_next.top_out    = state_next.top_cnt;
      state_next.bot_out    = state_next.bot_run;
      state_next.mid_out    = state_next.subtitle ? state_next.mid_cnt : VDR_BYTE_RST;
      state_next.prev_total = state_next.line_cnt;
    end
    // Bytes of one payload are not snapshotted: a decode that lands
    // between two byte reads gives a mix of old and new bytes, so a
    // host wanting a coherent word reads all its bytes within a field.
    // Register read, unmapped subaddresses return zero
    if (reg_rd_in) begin
      state_next.rvalid = 1'b1;
      unique case (reg_addr_in)
        VDR_ADDR_FOUND: begin
          state_next.rdata                     = VDR_BYTE_RST;
          state_next.rdata[VDR_FOUND_WIDE_BIT] = wide_found;
          state_next.rdata[VDR_FOUND_CAP_BIT]  = cap_found;
          state_next.rdata[VDR_FOUND_ENH_BIT]  = enh_found;
          state_next.rdata[VDR_FOUND_COPY_BIT] = copy_found;
        end
        VDR_ADDR_WIDE1: state_next.rdata = wide_data[7:0];
        VDR_ADDR_WIDE2: state_next.rdata = {2'b00, wide_data[13:8]};
        VDR_ADDR_ENH1:  state_next.rdata = enh_data[7:0];
        VDR_ADDR_ENH2:  state_next.rdata = enh_data[15:8];
        VDR_ADDR_ENH3: begin
          state_next.rdata                    = {4'h0, enh_data[19:16]};
          state_next.rdata[VDR_ENH3_RSVD_BIT] = 1'b0;
        end
        VDR_ADDR_COPY1: state_next.rdata = copy_data[7:0];
        VDR_ADDR_COPY2: state_next.rdata = copy_data[15:8];
        VDR_ADDR_COPY3: state_next.rdata = {4'h0, copy_data[19:16]};
        VDR_ADDR_CAP1:  state_next.rdata = {cap_data[VDR_PARITY_BIT], cap_data[6:0]};
        VDR_ADDR_CAP2:  state_next.rdata = {cap_data[8+VDR_PARITY_BIT], cap_data[14:8]};
        VDR_ADDR_LB_TOP: state_next.rdata = state_reg.top_out;
        VDR_ADDR_LB_MID: state_next.rdata = state_reg.mid_out;
        VDR_ADDR_LB_BOT: state_next.rdata = state_reg.bot_out;
        default:        state_next.rdata = VDR_BYTE_RST;
      endcase
    end
  end

  // State register; reset empties every count and the read answer, so
  // the whole bank reads 8'h00 until the first decode and field end
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state flops
  // so the host never sees a glitch of the read mux
  assign reg_rdata_out  = state_reg.rdata;
  assign reg_rvalid_out = state_reg.rvalid;

endmodule // vdr_readback
`default_nettype wire

// >>> bench/vdr_readback_props.sv
// Concurrent checks on the read port of the readback bank
`timescale 1ns/1ps
`default_nettype none
module vdr_readback_props
  import vdr_pkg::*;
(
  // Clock and reset
  input wire logic                 clk_sys_in,
  input wire logic                 rstn_in,
  // Caption slicer
  input wire logic                 cap_valid_in,
  input wire logic [VDR_CAP_W-1:0] cap_data_in,
  // Read port
  input wire logic                 reg_rd_in,
  input wire logic [7:0]           reg_addr_in,
  input wire logic [7:0]           reg_rdata_out,
  input wire logic                 reg_rvalid_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);

  // Every taken read answers one cycle later, and nothing else answers
  a_read_answers: assert property (reg_rd_in |=> reg_rvalid_out)
    else $error("read not answered");
  a_no_idle_answer: assert property (!reg_rd_in |=> !reg_rvalid_out)
    else $error("answer without read");
  // Read data only moves on a taken read, so a slow host sees a steady byte
  a_data_holds: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data moved without read");
  // Undefined upper bits read as zero
  a_wide2_top_zero: assert property (reg_rd_in && reg_addr_in == VDR_ADDR_WIDE2
    |=> reg_rdata_out[7:6] == 2'h0) else $error("wide byte two top bits set");
  a_enh3_top_zero: assert property (reg_rd_in && reg_addr_in == VDR_ADDR_ENH3
    |=> reg_rdata_out[7:6] == 2'h0) else $error("enhanced byte three top bits set");
  a_copy3_top_zero: assert property (reg_rd_in && reg_addr_in == VDR_ADDR_COPY3
    |=> reg_rdata_out[7:4] == 4'h0) else $error("copy byte three top bits set");
  a_found_upper_zero: assert property (reg_rd_in && reg_addr_in == VDR_ADDR_FOUND
    |=> reg_rdata_out[7:4] == 4'h0) else $error("status upper bits set");
  a_unmapped_zero: assert property (reg_rd_in && (reg_addr_in < VDR_ADDR_FOUND
    || reg_addr_in > VDR_ADDR_LB_BOT) |=> reg_rdata_out == 8'h00)
    else $error("unmapped address not zero");
  // Caption bytes come back whole, parity kept in bit 7
  a_cap1_parity_pos: assert property (cap_valid_in ##1 (reg_rd_in && !cap_valid_in
    && reg_addr_in == VDR_ADDR_CAP1) |=> reg_rdata_out == $past(cap_data_in[7:0], 2))
    else $error("caption byte one wrong");
  // Second byte's read is taken three edges after the capture
  a_cap2_parity_pos: assert property (cap_valid_in ##1 !cap_valid_in [*2]
    ##1 (reg_rd_in && !cap_valid_in && reg_addr_in == VDR_ADDR_CAP2)
    |=> reg_rdata_out == $past(cap_data_in[15:8], 4))
    else $error("caption byte two wrong");
endmodule // vdr_readback_props

bind vdr_readback vdr_readback_props u_props (
  .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .cap_valid_in(cap_valid_in),
  .cap_data_in(cap_data_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
  .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out));
`default_nettype wire

// >>> bench/vdr_host_model.sv
// Host model issuing single subaddressed register reads
`timescale 1ns/1ps
`default_nettype none
module vdr_host_model (
  // Clock
  input  wire logic       clk_sys_in,
  // Read port
  input  wire logic       reg_rvalid_in,
  input  wire logic [7:0] reg_rdata_in,
  output logic            reg_rd_out,
  output logic      [7:0] reg_addr_out
);
  // Idle until the first read
  initial begin
    reg_rd_out = 1'b0;
    reg_addr_out = 8'h00;
  end

  // Request is taken at the next edge; answer waited for under a bound
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    int n;
    reg_rd_out <= 1'b1;
    reg_addr_out <= a;
    @(posedge clk_sys_in);
    reg_rd_out <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (!reg_rvalid_in && n < 4);
    // A missing answer reads unknown and so fails the compare
    d = reg_rvalid_in ? reg_rdata_in : 8'hxx;
  endtask
endmodule // vdr_host_model
`default_nettype wire

// >>> bench/tb_vdr_readback.sv
// Self-checking bench of the readback bank against an integer model
`timescale 1ns/1ps
`default_nettype none
module tb_vdr_readback
  import vdr_pkg::*;
;
  logic        clk_sys_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic [3:0]  vld = 4'h0;
  logic [19:0] dat = 20'h0_0000;
  logic        pix = 1'b0;
  logic [7:0]  luma = 8'h00;
  logic        line_st = 1'b0;
  logic        fld_st = 1'b0;
  logic        fld_end = 1'b0;
  wire         rd;
  wire  [7:0]  addr;
  wire  [7:0]  rdata;
  wire         rvalid;
  int pay[4], flg[4], got[4];
  int top, mid, bot, prev_n, bad_count, num_checks, cycles;
  int seed = 32'h69c0d1af;

  // Clock at 100 MHz
  always #5 clk_sys_in = ~clk_sys_in;

  vdr_readback u_vdr_readback (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .wide_valid_in(vld[0]), .wide_data_in(dat[13:0]),
    .cap_valid_in(vld[1]), .cap_data_in(dat[15:0]),
    .enh_valid_in(vld[2]), .enh_data_in(dat),
    .copy_valid_in(vld[3]), .copy_data_in(dat),
    .pix_valid_in(pix), .luma_in(luma), .line_start_in(line_st),
    .field_start_in(fld_st), .field_end_in(fld_end),
    .reg_rd_in(rd), .reg_addr_in(addr), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid));

  vdr_host_model u_host (
    .clk_sys_in(clk_sys_in), .reg_rvalid_in(rvalid), .reg_rdata_in(rdata),
    .reg_rd_out(rd), .reg_addr_out(addr));

  // Expected byte at each subaddress, holes read zero
  function automatic int exp_byte(input int a);
    case (a)
      8'h90: return flg[0] | flg[1] << 1 | flg[2] << 2 | flg[3] << 3;
      8'h91: return pay[0] & 8'hff;
      8'h92: return pay[0] >> 8 & 8'h3f;
      8'h93: return pay[2] & 8'hff;
      8'h94: return pay[2] >> 8 & 8'hff;
      8'h95: return pay[2] >> 16 & 8'h0f;
      8'h96: return pay[3] & 8'hff;
      8'h97: return pay[3] >> 8 & 8'hff;
      8'h98: return pay[3] >> 16 & 8'h0f;
      8'h99: return pay[1] & 8'hff;
      8'h9a: return pay[1] >> 8 & 8'hff;
      8'h9b: return top;
      8'h9c: return mid;
      8'h9d: return bot;
      default: return 0;
    endcase
  endfunction

  task automatic cmp_byte(input logic [7:0] e, input logic [7:0] d);
    num_checks++;
    if (d !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, d);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a);
    logic [7:0] d;
    logic [7:0] e;
    u_host.read_reg(a, d);
    e = 8'(exp_byte(a));
    if (a == VDR_ADDR_ENH3) begin
      d[5] = 1'b0;
      e[5] = 1'b0;
    end
    cmp_byte(e, d);
  endtask

  // One slicer pulse, then its bytes read at once, first byte back to back
  task automatic svc(input int k);
    logic [19:0] v;
    int base;
    v = 20'($random(seed));
    vld[k] <= 1'b1;
    dat <= v;
    pay[k] = (k == 0) ? v & 16'h3fff : (k == 1) ? v & 16'hffff : v;
    flg[k] = 1;
    got[k] = 1;
    base = (k == 0) ? 8'h91 : (k == 1) ? 8'h99 : (k == 2) ? 8'h93 : 8'h96;
    @(posedge clk_sys_in);
    vld[k] <= 1'b0;
    // service bytes read right after the pulse, two for wide and caption, three for enhanced and copy
    for (int i = 0; i < ((k < 2) ? 2 : 3); i++) rd_chk(8'(base + i));
  endtask

  // A field of n two-pixel lines, black or not at random, then the counts
  task automatic field(input int n);
    int blk[$];
    int i, half, sub, cnt;
    fld_st <= 1'b1;
    for (i = 0; i < 4; i++) begin
      flg[i] = got[i];
      got[i] = 0;
    end
    @(posedge clk_sys_in);
    fld_st <= 1'b0;
    for (i = 0; i < 2 * n; i++) begin
      if (i % 2 == 0) blk.push_back($random(seed) & 1);
      line_st <= (i % 2 == 0);
      pix <= 1'b1;
      luma <= blk[i / 2] ? 8'({$random(seed)} % 33) : 8'(33 + {$random(seed)} % 223);
      @(posedge clk_sys_in);
    end
    line_st <= 1'b0;
    pix <= 1'b0;
    fld_end <= 1'b1;
    @(posedge clk_sys_in);
    fld_end <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    top = 0;
    while (top < n && blk[top]) top++;
    bot = 0;
    while (bot < n && blk[n - 1 - bot]) bot++;
    half = (prev_n == 0) ? n : prev_n / 2;
    sub = 0;
    cnt = 0;
    for (i = half; i < n; i++) begin
      if (blk[i]) cnt++;
      else if (cnt > 0) sub = 1;
    end
    mid = sub ? cnt : 0;
    prev_n = n;
    for (i = 8'h9b; i <= 8'h9d; i++) rd_chk(8'(i));
  endtask

  task automatic give_verdict;
    if (bad_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Hang guard, generous beside the few hundred cycles the run needs
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      give_verdict();
    end
  end

  initial begin
    repeat (20) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    @(posedge clk_sys_in);
    for (int a = 8'h8e; a <= 8'h9f; a++) rd_chk(8'(a));
    for (int r = 0; r < 4; r++) begin
      for (int k = 0; k < 4; k++) if (r == 0 || ($random(seed) & 1)) svc(k);
      rd_chk(VDR_ADDR_FOUND);
      field(6 + {$random(seed)} % 6);
      rd_chk(VDR_ADDR_FOUND);
      field(6 + {$random(seed)} % 6);
      rd_chk(VDR_ADDR_FOUND);
    end
    give_verdict();
  end
endmodule // tb_vdr_readback
`default_nettype wire
